// ==== srcp_pkg.sv ====
// constants for the serial register command parser
package srcp_pkg;
    // ----------------------------------------------------------------
    // clock and bit rates
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int BAUD_9600 = 9600;
    localparam int BAUD_19200 = 19200;
    localparam int BAUD_38400 = 38400;
    localparam int BAUD_57600 = 57600;
    localparam int BAUD_115200 = 115200;
    localparam logic [11:0] DIV_9600 = 12'(CLK_HZ / BAUD_9600);
    localparam logic [11:0] DIV_19200 = 12'(CLK_HZ / BAUD_19200);
    localparam logic [11:0] DIV_38400 = 12'(CLK_HZ / BAUD_38400);
    localparam logic [11:0] DIV_57600 = 12'(CLK_HZ / BAUD_57600);
    localparam logic [11:0] DIV_115200 = 12'(CLK_HZ / BAUD_115200);
    // ----------------------------------------------------------------
    // rate select codes
    // ----------------------------------------------------------------
    localparam logic [2:0] SEL_9600 = 3'h0;
    localparam logic [2:0] SEL_19200 = 3'h1;
    localparam logic [2:0] SEL_38400 = 3'h2;
    localparam logic [2:0] SEL_57600 = 3'h3;
    localparam logic [2:0] SEL_115200 = 3'h4;
    // ----------------------------------------------------------------
    // command bytes and frame lengths
    // ----------------------------------------------------------------
    localparam logic [7:0] OP_WRITE = 8'h57;
    localparam logic [7:0] OP_READ = 8'h52;
    localparam logic [7:0] RSP_ACK = 8'h06;
    localparam logic [7:0] RSP_ERR = 8'h15;
    localparam logic [2:0] WR_BODY_LEN = 3'h6;
    localparam logic [2:0] RD_BODY_LEN = 3'h2;
    localparam logic [2:0] RSP_LEN_ACK = 3'h1;
    localparam logic [2:0] RSP_LEN_READ = 3'h5;
    localparam logic [3:0] UART_LAST_BIT = 4'h9;
    localparam logic [3:0] TX_TICKS = 4'hA;

    typedef enum logic [2:0] {P_OPCODE, P_BODY, P_EXEC, P_RDWAIT, P_SEND} srcp_state_t;

    // map a rate code to a clock divisor; unknown codes give zero
    function automatic logic [11:0] srcp_div(input logic [2:0] sel);
        case (sel)
            SEL_9600: srcp_div = DIV_9600;
            SEL_19200: srcp_div = DIV_19200;
            SEL_38400: srcp_div = DIV_38400;
            SEL_57600: srcp_div = DIV_57600;
            SEL_115200: srcp_div = DIV_115200;
            default: srcp_div = 12'h000;
        endcase
    endfunction
endpackage

// ==== srcp_parser.sv ====
// serial register command parser: uart, frame decoder and responder
`timescale 1ns/1ps
// Overview of operation
// - write frame is seven bytes: 0x57, two address bytes, four data bytes.
// - read frame is three bytes: 0x52, two address bytes; register content returned.
// - address and data travel most significant byte first.
// - an invalid command is answered with a command-error byte.
// - rates 9600, 19200, 38400, 57600, 115200 baud; host must match.
// - after reset the link runs at 115200 baud until another is chosen.
module srcp_parser (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // serial link
    input wire logic uart_rxd,
    output logic uart_txd,
    // rate selection
    input wire logic baud_set,
    input wire logic [2:0] baud_sel,
    // internal register access
    output logic reg_wr,
    output logic reg_rd,
    output logic [15:0] reg_addr,
    output logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    // status
    output logic cmd_err
);
    // ----------------------------------------------------------------
    // rate divisor
    // ----------------------------------------------------------------
    logic [11:0] div_r, div_nxt;
    logic rx_busy_r, tx_busy_r;

    // a change only lands while the line is quiet, so no byte is split
    always_comb begin
        div_nxt = div_r;
        if (baud_set && !rx_busy_r && !tx_busy_r &&
            srcp_pkg::srcp_div(baud_sel) != 12'h000) begin
            div_nxt = srcp_pkg::srcp_div(baud_sel);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            div_r <= srcp_pkg::DIV_115200;
        end else begin
            div_r <= div_nxt;
        end
    end

    // ----------------------------------------------------------------
    // receiver
    // ----------------------------------------------------------------
    logic rx_s1_r, rx_s2_r;
    logic rx_busy_nxt;
    logic [11:0] rx_cnt_r, rx_cnt_nxt;
    logic [3:0] rx_bit_r, rx_bit_nxt;
    logic [7:0] rx_sh_r, rx_sh_nxt;
    logic byte_vld, byte_err;

    always_comb begin
        rx_busy_nxt = rx_busy_r;
        rx_cnt_nxt = rx_cnt_r;
        rx_bit_nxt = rx_bit_r;
        rx_sh_nxt = rx_sh_r;
        byte_vld = 1'b0;
        byte_err = 1'b0;
        if (!rx_busy_r) begin
            if (!rx_s2_r) begin
                rx_busy_nxt = 1'b1;
                rx_cnt_nxt = div_r >> 1;
                rx_bit_nxt = 4'h0;
            end
        end else if (rx_cnt_r != 12'h000) begin
            rx_cnt_nxt = rx_cnt_r - 12'h001;
        end else begin
            rx_cnt_nxt = div_r - 12'h001;
            rx_bit_nxt = rx_bit_r + 4'h1;
            if (rx_bit_r == 4'h0) begin
                // a glitch shorter than half a bit is not a start bit
                rx_busy_nxt = !rx_s2_r;
            end else if (rx_bit_r == srcp_pkg::UART_LAST_BIT) begin
                rx_busy_nxt = 1'b0;
                byte_vld = rx_s2_r;
                byte_err = !rx_s2_r;
            end else begin
                rx_sh_nxt = {rx_s2_r, rx_sh_r[7:1]};
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            rx_s1_r <= 1'b1;
            rx_s2_r <= 1'b1;
            rx_busy_r <= 1'b0;
            rx_cnt_r <= 12'h000;
            rx_bit_r <= 4'h0;
            rx_sh_r <= 8'h00;
        end else begin
            rx_s1_r <= uart_rxd;
            rx_s2_r <= rx_s1_r;
            rx_busy_r <= rx_busy_nxt;
            rx_cnt_r <= rx_cnt_nxt;
            rx_bit_r <= rx_bit_nxt;
            rx_sh_r <= rx_sh_nxt;
        end
    end

    // ----------------------------------------------------------------
    // frame decoder, responder and transmitter
    // ----------------------------------------------------------------
    srcp_pkg::srcp_state_t st_r, st_nxt;
    logic is_wr_r, is_wr_nxt;
    logic [2:0] len_r, len_nxt;
    logic [47:0] body_r, body_nxt;
    logic [39:0] rsp_r, rsp_nxt;
    logic [2:0] rsp_cnt_r, rsp_cnt_nxt;
    logic tx_busy_nxt, txd_nxt;
    logic [11:0] tx_cnt_r, tx_cnt_nxt;
    logic [3:0] tx_bit_r, tx_bit_nxt;
    logic [8:0] tx_sh_r, tx_sh_nxt;
    logic reg_wr_nxt, reg_rd_nxt, cmd_err_nxt;
    logic [15:0] reg_addr_nxt;
    logic [31:0] reg_wdata_nxt;

    always_comb begin
        st_nxt = st_r;
        is_wr_nxt = is_wr_r;
        len_nxt = len_r;
        body_nxt = body_r;
        rsp_nxt = rsp_r;
        rsp_cnt_nxt = rsp_cnt_r;
        reg_wr_nxt = 1'b0;
        reg_rd_nxt = 1'b0;
        cmd_err_nxt = 1'b0;
        reg_addr_nxt = reg_addr;
        reg_wdata_nxt = reg_wdata;
        tx_busy_nxt = tx_busy_r;
        tx_cnt_nxt = tx_cnt_r;
        tx_bit_nxt = tx_bit_r;
        tx_sh_nxt = tx_sh_r;
        txd_nxt = uart_txd;
        case (st_r)
            srcp_pkg::P_OPCODE: begin
                if (byte_vld && rx_sh_r == srcp_pkg::OP_WRITE) begin
                    is_wr_nxt = 1'b1;
                    len_nxt = srcp_pkg::WR_BODY_LEN;
                    st_nxt = srcp_pkg::P_BODY;
                end else if (byte_vld && rx_sh_r == srcp_pkg::OP_READ) begin
                    is_wr_nxt = 1'b0;
                    len_nxt = srcp_pkg::RD_BODY_LEN;
                    st_nxt = srcp_pkg::P_BODY;
                end else if (byte_vld || byte_err) begin
                    rsp_nxt = {srcp_pkg::RSP_ERR, 32'h0000_0000};
                    rsp_cnt_nxt = srcp_pkg::RSP_LEN_ACK;
                    cmd_err_nxt = 1'b1;
                    st_nxt = srcp_pkg::P_SEND;
                end
            end
            srcp_pkg::P_BODY: begin
                if (byte_err) begin
                    // a broken byte spoils the whole frame
                    rsp_nxt = {srcp_pkg::RSP_ERR, 32'h0000_0000};
                    rsp_cnt_nxt = srcp_pkg::RSP_LEN_ACK;
                    cmd_err_nxt = 1'b1;
                    st_nxt = srcp_pkg::P_SEND;
                end else if (byte_vld) begin
                    body_nxt = {body_r[39:0], rx_sh_r};
                    len_nxt = len_r - 3'h1;
                    if (len_r == 3'h1) begin
                        st_nxt = srcp_pkg::P_EXEC;
                    end
                end
            end
            srcp_pkg::P_EXEC: begin
                if (is_wr_r) begin
                    reg_wr_nxt = 1'b1;
                    reg_addr_nxt = body_r[47:32];
                    reg_wdata_nxt = body_r[31:0];
                    rsp_nxt = {srcp_pkg::RSP_ACK, 32'h0000_0000};
                    rsp_cnt_nxt = srcp_pkg::RSP_LEN_ACK;
                    st_nxt = srcp_pkg::P_SEND;
                end else begin
                    reg_rd_nxt = 1'b1;
                    reg_addr_nxt = body_r[15:0];
                    st_nxt = srcp_pkg::P_RDWAIT;
                end
            end
            srcp_pkg::P_RDWAIT: begin
                rsp_nxt = {srcp_pkg::RSP_ACK, reg_rdata};
                rsp_cnt_nxt = srcp_pkg::RSP_LEN_READ;
                st_nxt = srcp_pkg::P_SEND;
            end
            srcp_pkg::P_SEND: begin
                // bytes arriving while the answer goes out are dropped
                if (!tx_busy_r && rsp_cnt_r != 3'h0) begin
                    tx_busy_nxt = 1'b1;
                    tx_cnt_nxt = div_r - 12'h001;
                    tx_bit_nxt = 4'h0;
                    tx_sh_nxt = {1'b1, rsp_r[39:32]};
                    txd_nxt = 1'b0;
                    rsp_nxt = {rsp_r[31:0], 8'h00};
                    rsp_cnt_nxt = rsp_cnt_r - 3'h1;
                end else if (!tx_busy_r) begin
                    st_nxt = srcp_pkg::P_OPCODE;
                end
            end
            default: st_nxt = srcp_pkg::P_OPCODE;
        endcase
        if (tx_busy_r) begin
            if (tx_cnt_r != 12'h000) begin
                tx_cnt_nxt = tx_cnt_r - 12'h001;
            end else begin
                tx_cnt_nxt = div_r - 12'h001;
                tx_bit_nxt = tx_bit_r + 4'h1;
                if (tx_bit_r + 4'h1 == srcp_pkg::TX_TICKS) begin
                    tx_busy_nxt = 1'b0;
                end else begin
                    txd_nxt = tx_sh_r[0];
                    tx_sh_nxt = {1'b1, tx_sh_r[8:1]};
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            st_r <= srcp_pkg::P_OPCODE;
            is_wr_r <= 1'b0;
            len_r <= 3'h0;
            body_r <= 48'h0000_0000_0000;
            rsp_r <= 40'h00_0000_0000;
            rsp_cnt_r <= 3'h0;
            tx_busy_r <= 1'b0;
            tx_cnt_r <= 12'h000;
            tx_bit_r <= 4'h0;
            tx_sh_r <= 9'h1FF;
            uart_txd <= 1'b1;
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
            reg_addr <= 16'h0000;
            reg_wdata <= 32'h0000_0000;
            cmd_err <= 1'b0;
        end else begin
            st_r <= st_nxt;
            is_wr_r <= is_wr_nxt;
            len_r <= len_nxt;
            body_r <= body_nxt;
            rsp_r <= rsp_nxt;
            rsp_cnt_r <= rsp_cnt_nxt;
            tx_busy_r <= tx_busy_nxt;
            tx_cnt_r <= tx_cnt_nxt;
            tx_bit_r <= tx_bit_nxt;
            tx_sh_r <= tx_sh_nxt;
            uart_txd <= txd_nxt;
            reg_wr <= reg_wr_nxt;
            reg_rd <= reg_rd_nxt;
            reg_addr <= reg_addr_nxt;
            reg_wdata <= reg_wdata_nxt;
            cmd_err <= cmd_err_nxt;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [7:0] first_addr_r;
    always_ff @(posedge ref_clk) begin
        if (byte_vld && st_r == srcp_pkg::P_BODY && is_wr_r &&
            len_r == srcp_pkg::WR_BODY_LEN) begin
            first_addr_r <= rx_sh_r;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    a_wr_frame_len: assert property (
        byte_vld && st_r == srcp_pkg::P_OPCODE && rx_sh_r == srcp_pkg::OP_WRITE
        |=> st_r == srcp_pkg::P_BODY && is_wr_r && len_r == 3'h6)
        else $error("write opcode did not start a six byte body");
    a_rd_frame_len: assert property (
        byte_vld && st_r == srcp_pkg::P_OPCODE && rx_sh_r == srcp_pkg::OP_READ
        |=> st_r == srcp_pkg::P_BODY && !is_wr_r && len_r == 3'h2)
        else $error("read opcode did not start a two byte body");
    a_addr_msb_first: assert property (
        reg_wr |-> reg_addr[15:8] == first_addr_r)
        else $error("first address byte is not the high byte");
    a_bad_op_err: assert property (
        byte_vld && st_r == srcp_pkg::P_OPCODE && rx_sh_r != srcp_pkg::OP_WRITE &&
        rx_sh_r != srcp_pkg::OP_READ
        |=> cmd_err && rsp_cnt_r == 3'h1 && rsp_r[39:32] == srcp_pkg::RSP_ERR)
        else $error("invalid opcode not answered with error");
    a_rate_legal: assert property (
        div_r == srcp_pkg::DIV_9600 || div_r == srcp_pkg::DIV_19200 ||
        div_r == srcp_pkg::DIV_38400 || div_r == srcp_pkg::DIV_57600 ||
        div_r == srcp_pkg::DIV_115200)
        else $error("divisor is not a supported rate");
    a_rate_default: assert property (
        $past(!rstn) |-> div_r == srcp_pkg::DIV_115200)
        else $error("rate after reset is not 115200");
    a_rd_answer: assert property (
        reg_rd |=> rsp_cnt_r == 3'h5 && rsp_r[39:32] == srcp_pkg::RSP_ACK &&
        rsp_r[31:0] == $past(reg_rdata))
        else $error("read answer is not ack plus data");
    a_wr_ack: assert property (
        reg_wr |-> ##[1:2] (uart_txd == 1'b0 && rsp_cnt_r == 3'h0))
        else $error("write ack did not start");
    c_write: cover property (reg_wr);
    c_read: cover property (reg_rd ##2 tx_busy_r);
    c_error: cover property (cmd_err);
endmodule // srcp_parser

// ==== srcp_host_model.sv ====
// host terminal model: byte sender and receiver on the serial lines
`timescale 1ns/1ps
module srcp_host_model (
    // clock
    input wire logic ref_clk,
    // serial lines
    input wire logic dev_txd,
    output logic host_txd
);
    // ----------------------------------------------------------------
    // sender
    // ----------------------------------------------------------------
    initial begin
        host_txd = 1'b1;
    end

    // the last byte of a frame keeps a short stop bit, since the answer
    // may begin mid stop bit; the line then simply idles high
    task automatic send_byte(input logic [7:0] b, input int div, input bit last);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            host_txd = fr[i];
            repeat ((i == 9 && last) ? div / 4 : div) @(negedge ref_clk);
        end
    endtask

    // a byte whose stop bit is low; the low stop is cut short so the
    // receiver takes the tail as a glitch, not as a new start bit
    task automatic send_bad_byte(input logic [7:0] b, input int div);
        logic [9:0] fr;
        fr = {1'b0, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            host_txd = fr[i];
            repeat ((i == 9) ? (3 * div) / 4 : div) @(negedge ref_clk);
        end
        host_txd = 1'b1;
    endtask

    // ----------------------------------------------------------------
    // receiver
    // ----------------------------------------------------------------
    // returns at the middle of the stop bit, so back to back bytes are caught
    task automatic recv_byte(output logic [7:0] b, output logic ok, input int div);
        int n;
        n = 0;
        b = 8'h00;
        while (dev_txd !== 1'b0 && n < 40 * div) begin
            @(negedge ref_clk);
            n++;
        end
        repeat (div / 2) @(negedge ref_clk);
        ok = (dev_txd === 1'b0);
        for (int i = 0; i < 8; i++) begin
            repeat (div) @(negedge ref_clk);
            b[i] = dev_txd;
        end
        repeat (div) @(negedge ref_clk);
        ok = ok && (n < 40 * div) && (dev_txd === 1'b1);
    endtask
endmodule // srcp_host_model

// ==== srcp_parser_tb.sv ====
// self-checking testbench of the serial register command parser
`timescale 1ns/1ps
module srcp_parser_tb;
    logic ref_clk, rstn, uart_rxd, uart_txd, baud_set;
    logic [2:0] baud_sel;
    logic reg_wr, reg_rd, cmd_err;
    logic [15:0] reg_addr, wr_addr, rd_addr;
    logic [31:0] reg_wdata, reg_rdata, wr_data;
    int error_cnt = 0;
    int compares = 0;
    int wr_seen = 0;
    int rd_seen = 0;
    int err_seen = 0;
    int div = 173;

    srcp_parser u_dut (.ref_clk(ref_clk), .rstn(rstn), .uart_rxd(uart_rxd),
        .uart_txd(uart_txd), .baud_set(baud_set), .baud_sel(baud_sel),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cmd_err(cmd_err));
    srcp_host_model u_host (.ref_clk(ref_clk), .dev_txd(uart_txd), .host_txd(uart_rxd));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // ----------------------------------------------------------------
    // strobe monitor: counts high cycles, so a stretched pulse shows up
    // ----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (reg_wr === 1'b1) begin
            wr_seen++;
            wr_addr = reg_addr;
            wr_data = reg_wdata;
        end
        if (reg_rd === 1'b1) begin
            rd_seen++;
            rd_addr = reg_addr;
        end
        if (cmd_err === 1'b1) begin
            err_seen++;
        end
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("compares %0d, error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic send_frame(input logic [7:0] f[$]);
        for (int i = 0; i < f.size(); i++) begin
            u_host.send_byte(f[i], div, i == f.size() - 1);
        end
    endtask

    task automatic get_byte(output logic [7:0] b);
        logic ok;
        u_host.recv_byte(b, ok, div);
        chk({31'h0, ok}, 32'h1);
    endtask

    // the answer is still in its stop bit when get_byte returns
    task automatic idle_gap();
        repeat (div + 4) @(negedge ref_clk);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    // write at the rate left by reset
    task automatic test_write();
        logic [7:0] b;
        int w0;
        w0 = wr_seen;
        send_frame('{8'h57, 8'h04, 8'h10, 8'h11, 8'h22, 8'h33, 8'h44});
        get_byte(b);
        chk({24'h0, b}, 32'h06);
        chk(32'(wr_seen - w0), 32'h1);
        chk({16'h0, wr_addr}, 32'h0410);
        chk(wr_data, 32'h11223344);
        idle_gap();
    endtask

    // read right after the write answer, data returned msb first
    task automatic test_read();
        logic [7:0] b;
        logic [7:0] exp[5];
        int r0;
        exp = '{8'h06, 8'hA1, 8'hB2, 8'hC3, 8'hD4};
        r0 = rd_seen;
        send_frame('{8'h52, 8'h04, 8'h10});
        for (int i = 0; i < 5; i++) begin
            get_byte(b);
            chk({24'h0, b}, {24'h0, exp[i]});
        end
        chk(32'(rd_seen - r0), 32'h1);
        chk({16'h0, rd_addr}, 32'h0410);
        idle_gap();
    endtask

    // every rate code, each answered with the error byte at that rate
    task automatic test_rates();
        logic [7:0] b;
        int rates[5];
        int e0;
        rates = '{9600, 19200, 38400, 57600, 115200};
        for (int c = 0; c < 5; c++) begin
            @(negedge ref_clk);
            baud_sel = 3'(c);
            baud_set = 1'b1;
            @(negedge ref_clk);
            baud_set = 1'b0;
            div = 20_000_000 / rates[c];
            e0 = err_seen;
            send_frame('{8'hC3});
            get_byte(b);
            chk({24'h0, b}, {24'h0, srcp_pkg::RSP_ERR});
            chk(32'(err_seen - e0), 32'h1);
            idle_gap();
        end
    endtask

    // a byte with a broken stop bit is refused with the error byte
    task automatic test_framing();
        logic [7:0] b;
        int e0;
        int w0;
        e0 = err_seen;
        w0 = wr_seen;
        u_host.send_bad_byte(8'h57, div);
        get_byte(b);
        chk({24'h0, b}, {24'h0, srcp_pkg::RSP_ERR});
        chk(32'(err_seen - e0), 32'h1);
        chk(32'(wr_seen - w0), 32'h0);
        idle_gap();
    endtask

    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        baud_set = 1'b0;
        baud_sel = 3'h4;
        reg_rdata = 32'hA1B2C3D4;
        repeat (5) @(negedge ref_clk);
        rstn = 1'b1;
        test_write();
        test_read();
        test_rates();
        test_framing();
        report_and_stop();
    end

    // the slow rates dominate: about 116000 cycles in all
    initial begin
        repeat (150000) @(posedge ref_clk);
        error_cnt++;
        $display("wrong value at %0t: run did not finish", $time);
        report_and_stop();
    end
endmodule // srcp_parser_tb
